//--- include/pcel_defines.vh
// Register offsets, field positions and reset values for the PCI error latch block.
`ifndef PCEL_DEFINES_VH
`define PCEL_DEFINES_VH

// Byte offsets of the 32-bit words; each 64-bit register is a low and a high word.
`define PCEL_OFF_STATUS_LO     8'h00
`define PCEL_OFF_STATUS_HI     8'h04
`define PCEL_OFF_CAPTURE_LO    8'h08
`define PCEL_OFF_CAPTURE_HI    8'h0C
`define PCEL_OFF_SPECIAL_LO    8'h10
`define PCEL_OFF_SPECIAL_HI    8'h14
`define PCEL_OFF_SPARSE_LO     8'h18
`define PCEL_OFF_SPARSE_HI     8'h1C
`define PCEL_OFF_IOCTL_LO      8'h20
`define PCEL_OFF_IOCTL_HI      8'h24

// Status register bit positions within the low word.
`define PCEL_BIT_WRITE_PARITY  0
`define PCEL_BIT_READ_PARITY   2
`define PCEL_BIT_TIMEOUT       5
`define PCEL_BIT_NMI           6
`define PCEL_NUM_FLAGS         4

// I/O control register: enables in the high word (bit 63 is high-word bit 31).
`define PCEL_EN_WRITE_PARITY   31
`define PCEL_EN_READ_PARITY    29
`define PCEL_EN_TIMEOUT        26
`define PCEL_EN_NMI            25
`define PCEL_IOCTL_EN_MSB      31
`define PCEL_IOCTL_EN_LSB      25
`define PCEL_IOCTL_EN_RESET    7'h00
// PCI reset bit in the low word.
`define PCEL_BIT_PCI_RESET     0
`define PCEL_PCI_RESET_RESET   1'h0

// Capture register fields.
`define PCEL_CMD_WIDTH         5
`define PCEL_ADDR_WIDTH        32

// Sparse upper address field.
`define PCEL_SPARSE_WIDTH      5
`define PCEL_SPARSE_RESET      5'h00

`endif

//--- hw/pcel_flag.v
// One sticky error flag: set by hardware, cleared by software or reset, set beating clear.
`default_nettype none

module pcel_flag (
	input  wire clk_i,
	input  wire rst_i,
	input  wire set_i,
	input  wire clr_i,
	output reg  flag_o
);

	always @(posedge clk_i) begin
		if (rst_i) begin
			flag_o <= 1'b0;
		end else if (set_i) begin
			flag_o <= 1'b1;
		end else if (clr_i) begin
			flag_o <= 1'b0;
		end
	end

endmodule

`default_nettype wire

//--- hw/pcel_top.v
// Error status, error capture, special cycle launch and sparse address extension registers.
//
// The placing of the registers and the Wishbone interface to the registers were chosen for this implementation.
`default_nettype none
`include "pcel_defines.vh"

module pcel_top (
	input  wire        clk_i,
	input  wire        rst_i,
	// Wishbone classic slave.
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	// Error events from the PCI interface.
	input  wire        write_parity_err_i,
	input  wire        read_parity_err_i,
	input  wire        device_timeout_i,
	input  wire        nmi_i,
	// Start of each PCI cycle with its address and command.
	input  wire        pci_cycle_start_i,
	input  wire [31:0] pci_addr_i,
	input  wire [4:0]  pci_cmd_i,
	// Special cycle request to the PCI master logic.
	output reg         special_req_o,
	output reg  [63:0] special_msg_o,
	input  wire        special_done_i,
	// Upper PCI address bits for sparse memory accesses.
	output reg  [4:0]  sparse_addr_o,
	// Level from the PCI reset bit of the control register.
	output reg         pci_reset_o,
	// Hardware error interrupt on the host system bus.
	output reg         hw_error_o
);

	wire        bus_req;
	wire        wr_fire;
	wire        rd_take;
	wire [31:0] wmask;
	wire [31:0] wdata_m;
	wire        stall;

	reg  [`PCEL_NUM_FLAGS-1:0]   flag_set;
	reg  [`PCEL_NUM_FLAGS-1:0]   flag_clr;
	wire [`PCEL_NUM_FLAGS-1:0]   flags;
	wire [`PCEL_NUM_FLAGS-1:0]   enables;
	wire [`PCEL_NUM_FLAGS-1:0]   w1c_bits;

	reg  [6:0]                   ioctl_en;
	reg  [`PCEL_ADDR_WIDTH-1:0]  cap_addr;
	reg  [`PCEL_CMD_WIDTH-1:0]   cap_cmd;
	wire                         frozen;
	wire                         parity_event;

	reg  [31:0]                  msg_lo_stage;
	wire [63:0]                  launch_msg;
	wire                         launch;
	reg                          queued_valid;
	reg  [63:0]                  queued_msg;

	reg  [31:0]                  next_rdata;

	// The slave answers every request one cycle after it appears, with one exception.
	// A launch write that finds both special cycle slots taken is held off.
	// Ack then stays low until the PCI side reports a completed cycle.
	// The master keeps its request standing during that wait, so nothing is lost.
	// Read data is registered together with ack, so it is valid while ack is high.
	// Writes return zero on the data lines, which keeps the bus quiet.
	assign bus_req = wb_cyc_i & wb_stb_i;
	// A write takes effect only at the edge where the master sees ack.
	assign wr_fire = bus_req & wb_we_i & wb_ack_o;
	assign rd_take = bus_req & ~wb_ack_o;

	genvar b;
	generate
		for (b = 0; b < 4; b = b + 1) begin : g_mask
			assign wmask[8*b+7:8*b] = {8{wb_sel_i[b]}};
		end
	endgenerate

	assign wdata_m = wb_dat_i & wmask;

	// A launch write waits for ack while both request slots are taken.
	assign stall = wb_we_i & (wb_adr_i == `PCEL_OFF_SPECIAL_HI) & queued_valid;

	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= rd_take & ~stall;
		end
	end

	// Each flag is a separate sticky bit in its own small module.
	// Setting takes priority over clearing, so an event that coincides with
	// a software clear or with the PCI reset bit is never lost.
	// Only the power-up reset beats an event in the same cycle.
	// Bits 1, 3 and 4 of the status word are not kept here and read as zero.
	// Event sources in flag order: write parity, read parity, timeout, nonmaskable.
	assign w1c_bits = {wdata_m[`PCEL_BIT_NMI],
	                   wdata_m[`PCEL_BIT_TIMEOUT],
	                   wdata_m[`PCEL_BIT_READ_PARITY],
	                   wdata_m[`PCEL_BIT_WRITE_PARITY]};

	assign enables = {ioctl_en[`PCEL_EN_NMI - `PCEL_IOCTL_EN_LSB],
	                  ioctl_en[`PCEL_EN_TIMEOUT - `PCEL_IOCTL_EN_LSB],
	                  ioctl_en[`PCEL_EN_READ_PARITY - `PCEL_IOCTL_EN_LSB],
	                  ioctl_en[`PCEL_EN_WRITE_PARITY - `PCEL_IOCTL_EN_LSB]};

	always @* begin
		flag_set[0] = write_parity_err_i;
		flag_set[1] = read_parity_err_i;
		flag_set[2] = device_timeout_i;
		flag_set[3] = nmi_i;
	end

	genvar f;
	generate
		for (f = 0; f < `PCEL_NUM_FLAGS; f = f + 1) begin : g_flag
			always @* begin
				flag_clr[f] = pci_reset_o |
				              (wr_fire & (wb_adr_i == `PCEL_OFF_STATUS_LO) & w1c_bits[f]);
			end

			pcel_flag u_flag (
				.clk_i  (clk_i),
				.rst_i  (rst_i),
				.set_i  (flag_set[f]),
				.clr_i  (flag_clr[f]),
				.flag_o (flags[f])
			);
		end
	endgenerate

	// The interrupt follows the enabled flags as a level.
	// It is registered, so it rises one cycle after the flag and falls one cycle
	// after the last enabled flag is cleared or its enable is removed.
	// Software may therefore clear a flag and find the line low shortly after.
	// Disabling an enable masks the flag without clearing it.
	always @(posedge clk_i) begin
		if (rst_i) begin
			hw_error_o <= 1'b0;
		end else begin
			hw_error_o <= |(flags & enables);
		end
	end

	// Control register: enables and the PCI reset bit.
	// The enables sit in the high word and honour the byte selects.
	// The PCI reset bit sits in the low word; while it is one every flag is cleared
	// in each cycle without its event, and software writes it back to zero to release them.
	// The level also leaves the block so that the PCI side can be reset.
	always @(posedge clk_i) begin
		if (rst_i) begin
			ioctl_en    <= `PCEL_IOCTL_EN_RESET;
			pci_reset_o <= `PCEL_PCI_RESET_RESET;
		end else if (wr_fire) begin
			if (wb_adr_i == `PCEL_OFF_IOCTL_HI) begin
				ioctl_en <= (ioctl_en & ~wmask[`PCEL_IOCTL_EN_MSB:`PCEL_IOCTL_EN_LSB]) |
				            wdata_m[`PCEL_IOCTL_EN_MSB:`PCEL_IOCTL_EN_LSB];
			end
			if ((wb_adr_i == `PCEL_OFF_IOCTL_LO) && wb_sel_i[0]) begin
				pci_reset_o <= wb_dat_i[`PCEL_BIT_PCI_RESET];
			end
		end
	end

	// Sparse upper address bits.
	// Only the five low bits are stored; the rest of the register reads zero.
	// The stored bits are driven straight to the PCI address path, where they
	// supply the top address bits of every sparse memory access.
	// Writes to the high word of this register are ignored.
	always @(posedge clk_i) begin
		if (rst_i) begin
			sparse_addr_o <= `PCEL_SPARSE_RESET;
		end else if (wr_fire && (wb_adr_i == `PCEL_OFF_SPARSE_LO) && wb_sel_i[0]) begin
			sparse_addr_o <= wb_dat_i[`PCEL_SPARSE_WIDTH-1:0];
		end
	end

	// A parity flag that is set, or is being raised now, holds the capture.
	assign parity_event = write_parity_err_i | read_parity_err_i;
	assign frozen       = flags[0] | flags[1] | parity_event;

	// No reset here: the last failing address survives every reset.
	// Software reads it after a reset to learn which cycle failed.
	// The capture reads as unknown until the first PCI cycle has been seen.
	// A parity event in the same cycle as its own cycle start keeps the previous
	// address: the freeze already applies while the event input is high.
	// Clearing the matching flag releases the freeze at the next cycle start.
	always @(posedge clk_i) begin
		if (pci_cycle_start_i && !frozen) begin
			cap_addr <= pci_addr_i;
			cap_cmd  <= pci_cmd_i;
		end
	end

	// Low word is staged; writing the high word launches the cycle.
	// The staged low word persists, so repeated launches may write only
	// the high word when the low half of the message does not change.
	// The message is taken whole at the launch, so a later low word write
	// does not disturb a cycle that is already pending or queued.
	assign launch     = wr_fire & (wb_adr_i == `PCEL_OFF_SPECIAL_HI);
	assign launch_msg = {wdata_m, msg_lo_stage};

	always @(posedge clk_i) begin
		if (rst_i) begin
			msg_lo_stage <= 32'h00000000;
		end else if (wr_fire && (wb_adr_i == `PCEL_OFF_SPECIAL_LO)) begin
			msg_lo_stage <= (msg_lo_stage & ~wmask) | wdata_m;
		end
	end

	// One cycle may be active on the PCI side and one more may wait behind it.
	// A completion pulse either drops the request or moves the queued message
	// into place without a gap, keeping the request high.
	// A launch in the same cycle as a completion is accepted as well.
	// Completion pulses while no request is active are ignored.
	always @(posedge clk_i) begin
		if (rst_i) begin
			special_req_o <= 1'b0;
			special_msg_o <= 64'h0000000000000000;
			queued_valid  <= 1'b0;
			queued_msg    <= 64'h0000000000000000;
		end else begin
			if (special_req_o && special_done_i) begin
				if (queued_valid) begin
					special_msg_o <= queued_msg;
					queued_valid  <= 1'b0;
					if (launch) begin
						queued_msg   <= launch_msg;
						queued_valid <= 1'b1;
					end
				end else if (launch) begin
					special_msg_o <= launch_msg;
				end else begin
					special_req_o <= 1'b0;
				end
			end else if (launch) begin
				if (!special_req_o) begin
					special_req_o <= 1'b1;
					special_msg_o <= launch_msg;
				end else begin
					queued_valid <= 1'b1;
					queued_msg   <= launch_msg;
				end
			end
		end
	end

	// Read data for the word addressed; unmapped and write-only words read zero.
	// Every read completes normally; no address produces a bus error.
	// Reserved bits are forced to zero here rather than stored anywhere.
	// The special message words are write-only and always return zeros.
	// Both words of the control register read back what software stored.
	always @* begin
		next_rdata = 32'h00000000;
		case (wb_adr_i)
			`PCEL_OFF_STATUS_LO: begin
				next_rdata[`PCEL_BIT_WRITE_PARITY] = flags[0];
				next_rdata[`PCEL_BIT_READ_PARITY]  = flags[1];
				next_rdata[`PCEL_BIT_TIMEOUT]      = flags[2];
				next_rdata[`PCEL_BIT_NMI]          = flags[3];
			end
			`PCEL_OFF_STATUS_HI: begin
				next_rdata = 32'h00000000;
			end
			`PCEL_OFF_CAPTURE_LO: begin
				next_rdata = cap_addr;
			end
			`PCEL_OFF_CAPTURE_HI: begin
				next_rdata[`PCEL_CMD_WIDTH-1:0] = cap_cmd;
			end
			`PCEL_OFF_SPECIAL_LO: begin
				next_rdata = 32'h00000000;
			end
			`PCEL_OFF_SPECIAL_HI: begin
				next_rdata = 32'h00000000;
			end
			`PCEL_OFF_SPARSE_LO: begin
				next_rdata[`PCEL_SPARSE_WIDTH-1:0] = sparse_addr_o;
			end
			`PCEL_OFF_IOCTL_LO: begin
				next_rdata[`PCEL_BIT_PCI_RESET] = pci_reset_o;
			end
			`PCEL_OFF_IOCTL_HI: begin
				next_rdata[`PCEL_IOCTL_EN_MSB:`PCEL_IOCTL_EN_LSB] = ioctl_en;
			end
			default: begin
				next_rdata = 32'h00000000;
			end
		endcase
	end

	// Capture writes are accepted and ignored since no branch above stores them.
	// The data register loads only when a request is answered, so it keeps its
	// value while the master waits on a held-off launch write.
	// It returns zero during writes.
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h00000000;
		end else if (rd_take && !stall) begin
			wb_dat_o <= wb_we_i ? 32'h00000000 : next_rdata;
		end
	end

endmodule

`default_nettype wire

//--- sim/pcel_top_monitor.sv
// Checker for the PCI error latch register block, bound to its top module.
`default_nettype none
module pcel_top_monitor (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        special_req_o,
	input wire logic [63:0] special_msg_o,
	input wire logic        special_done_i,
	input wire logic [4:0]  sparse_addr_o,
	input wire logic        hw_error_o
);
	logic       sw;
	logic [4:0] sd;
	always_ff @(posedge clk_i) begin
		sw <= wb_ack_o && wb_we_i && wb_adr_i == 8'h18;
		sd <= wb_dat_i[4:0];
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence s_rd; wb_ack_o && !wb_we_i; endsequence
	property p_ack; s_req && !(wb_we_i && wb_adr_i == 8'h14) |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("request not acknowledged");
	property p_stall; s_req && wb_we_i && wb_adr_i == 8'h14 |-> ##[1:60] wb_ack_o; endproperty
	a_stall: assert property (p_stall) else $error("launch write never acknowledged");
	property p_ackp; wb_ack_o |=> !wb_ack_o; endproperty
	a_ackp: assert property (p_ackp) else $error("ack longer than one cycle");
	property p_mbz;
		s_rd ##0 (wb_adr_i == 8'h04 || wb_adr_i == 8'h10 || wb_adr_i == 8'h14 || wb_adr_i == 8'h1C)
			|-> wb_dat_o == 32'h0;
	endproperty
	a_mbz: assert property (p_mbz) else $error("zero word read nonzero");
	property p_sts; s_rd ##0 wb_adr_i == 8'h00 |-> wb_dat_o[31:7] == 25'h0; endproperty
	a_sts: assert property (p_sts) else $error("status reserved bits set");
	property p_cap; s_rd ##0 wb_adr_i == 8'h0C |-> wb_dat_o[31:5] == 27'h0; endproperty
	a_cap: assert property (p_cap) else $error("capture reserved bits set");
	property p_req; special_req_o && !special_done_i |=> special_req_o && $stable(special_msg_o); endproperty
	a_req: assert property (p_req) else $error("special request dropped early");
	property p_launch;
		wb_ack_o && wb_we_i && wb_adr_i == 8'h14 && !special_req_o
			|=> special_req_o && special_msg_o[63:32] == $past(wb_dat_i);
	endproperty
	a_launch: assert property (p_launch) else $error("special cycle not launched");
	property p_sparse; sw |-> sparse_addr_o == sd; endproperty
	a_sparse: assert property (p_sparse) else $error("sparse bits not driven");
	property p_rst;
		disable iff (1'b0) rst_i |=> !wb_ack_o && !special_req_o && !hw_error_o && sparse_addr_o == 5'h00;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not reset");
endmodule
bind pcel_top pcel_top_monitor mon_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
	.wb_dat_o, .wb_ack_o, .special_req_o, .special_msg_o, .special_done_i, .sparse_addr_o, .hw_error_o);
`default_nettype wire

//--- sim/pcel_pci_agent.sv
// Behavioural PCI master that runs special cycles after a set delay and logs their messages.
`default_nettype none
module pcel_pci_agent (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        req_i,
	input  wire logic [63:0] msg_i,
	input  wire logic [3:0]  dly_i,
	output wire logic        done_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        d = 1'b0;
	logic [3:0]  cnt = 4'h0;
	logic [63:0] log [$];
	assign done_o = d;
	always @(posedge clk_i) begin
		if (rst_i || d) begin
			d <= 1'b0;
			cnt <= 4'h0;
		end else if (req_i) begin
			if (cnt == dly_i) begin
				d <= 1'b1;
				log.push_back(msg_i);
			end
			cnt <= cnt + 4'h1;
		end
	end
endmodule
`default_nettype wire

//--- sim/pcel_top_tb.sv
// Self-checking testbench for the PCI error latch register block.
`default_nettype none
module pcel_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic        pci_cycle_start_i = 1'b0, special_done_i, special_req_o, wb_ack_o, hw_error_o;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, pci_addr_i = 32'h0, q, a;
	logic [4:0]  pci_cmd_i = 5'h00, sparse_addr_o, c;
	logic [3:0]  ev = 4'h0, dly = 4'h0;
	logic [63:0] special_msg_o, am;
	int          mismatches = 0, num_checks = 0;
	int          fbit[4] = '{0, 2, 5, 6};
	int          ebit[4] = '{31, 29, 26, 25};
	pcel_top dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hF), .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .write_parity_err_i(ev[0]), .read_parity_err_i(ev[1]), .device_timeout_i(ev[2]),
		.nmi_i(ev[3]), .pci_cycle_start_i, .pci_addr_i, .pci_cmd_i, .special_req_o, .special_msg_o,
		.special_done_i, .sparse_addr_o, .pci_reset_o(), .hw_error_o);
	pcel_pci_agent ag_u (.clk_i, .rst_i, .req_i(special_req_o), .msg_i(special_msg_o), .dly_i(dly),
		.done_o(special_done_i));
	always #5 clk_i = ~clk_i;
	function automatic logic [31:0] sb(int b);
		return 32'h1 << b;
	endfunction
	task automatic chk(string n, logic [63:0] s, logic [63:0] e);
		num_checks++;
		if (s !== e) begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic bus(logic w, logic [7:0] ad, logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= ad;
		wb_dat_i <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic rc(string n, logic [7:0] ad, logic [31:0] e);
		bus(1'b0, ad, 32'h0);
		chk(n, q, e);
	endtask
	task automatic pl(int i);
		@(posedge clk_i);
		ev[i] <= 1'b1;
		@(posedge clk_i);
		ev[i] <= 1'b0;
	endtask
	task automatic cy(logic [31:0] ad, logic [4:0] cm);
		@(posedge clk_i);
		pci_cycle_start_i <= 1'b1;
		pci_addr_i <= ad;
		pci_cmd_i <= cm;
		@(posedge clk_i);
		pci_cycle_start_i <= 1'b0;
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		a = $urandom(32'h1F861542);
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rc("sparse reset", 8'h18, 32'h0);
		for (int i = 0; i < 4; i++) begin
			pl(i);
			rc("flag", 8'h00, sb(fbit[i]));
			chk("irq masked", hw_error_o, 1'b0);
			bus(1'b1, 8'h24, sb(ebit[i]));
			repeat (2) @(posedge clk_i);
			chk("irq", hw_error_o, 1'b1);
			bus(1'b1, 8'h00, sb(fbit[i]));
			rc("w1c", 8'h00, 32'h0);
			chk("irq drop", hw_error_o, 1'b0);
		end
		pl(3);
		bus(1'b1, 8'h20, 32'h1);
		bus(1'b1, 8'h20, 32'h0);
		rc("pci reset", 8'h00, 32'h0);
		$display("test flags done");
		a = $urandom;
		c = $urandom;
		cy(a, c);
		rc("addr", 8'h08, a);
		rc("cmd", 8'h0C, {27'h0, c});
		pl(0);
		cy(~a, ~c);
		bus(1'b1, 8'h08, ~a);
		rc("frozen", 8'h08, a);
		bus(1'b1, 8'h00, 32'h1);
		cy(~a, ~c);
		rc("resumed", 8'h08, ~a);
		@(posedge clk_i);
		rst_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		rc("kept", 8'h08, ~a);
		$display("test capture done");
		for (int k = 0; k < 2; k++) begin
			dly <= k ? 4'hF : 4'h0;
			am = {$urandom, $urandom};
			bus(1'b1, 8'h10, am[31:0]);
			bus(1'b1, 8'h14, am[63:32]);
			bus(1'b1, 8'h14, ~am[63:32]);
			bus(1'b1, 8'h14, am[63:32] ^ 32'h0000FFFF);
			for (int t = 0; t < 100 && ag_u.log.size() < 3 * k + 3; t++)
				@(posedge clk_i);
			chk("msg one", ag_u.log[3 * k], am);
			chk("msg two", ag_u.log[3 * k + 1], {~am[63:32], am[31:0]});
			chk("msg three", ag_u.log[3 * k + 2], {am[63:32] ^ 32'h0000FFFF, am[31:0]});
		end
		chk("msg count", ag_u.log.size(), 6);
		rc("msg read", 8'h10, 32'h0);
		$display("test special done");
		c = $urandom;
		bus(1'b1, 8'h18, {27'h7FFFFFF, c});
		@(posedge clk_i);
		chk("sparse pins", sparse_addr_o, c);
		rc("sparse read", 8'h18, {27'h0, c});
		rc("sparse high", 8'h1C, 32'h0);
		rc("status high", 8'h04, 32'h0);
		rc("unmapped", 8'h40, 32'h0);
		$display("test sparse done");
		complete_run();
	end
	// The whole sequence needs a few hundred cycles; the 100 us limit leaves ample margin.
	initial begin
		#100us;
		mismatches++;
		complete_run();
	end
endmodule
`default_nettype wire
